/* design/usfg_top.sv */
// serial port status byte, host decode, receiver and gated transmitter
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Overview of operation
// - a read of the control/status port returns the live status byte
// - bit 7 follows the request-to-send input level
// - bit 6 set while the line holds a continuous space level
// - bit 5 set when no valid stop bit follows a character
// - bit 4 set when a new character overwrites an unread one
// - bit 3 set when received parity disagrees with computed parity
// - bit 2 is 1 only when every handed character has left
// - bit 1 is 1 while a received character waits for the host
// - bit 0 is 1 when the transmitter can take another character
// - terminal-ready input is not in status, gates sending like enable
// - terminal-ready low lets the current character finish, then stops
// - characters are still accepted while held off, sent once re-enabled
// - command with fault_flag_clear set clears parity, overrun, framing
// - receiver_on low stops receiver and suppresses ready bit and request
// - first control write after reset or an internal-reset command is mode, later ones are commands
// - transmit enable low masks the ready request at once, still accepts
// ----------------------------------------------------------------
module usfg_top #(
    parameter int FIFO_DEPTH = usfg_pkg::FIFO_DEPTH
) (
    input  wire logic       i_clk,       // 200 MHz system clock
    input  wire logic       i_rst,       // async reset, high
    input  wire logic [3:0] i_addr,      // host port offset
    input  wire logic       i_rd,        // host read strobe
    input  wire logic       i_wr,        // host write strobe
    input  wire logic [7:0] i_wdata,     // host write data
    output logic      [7:0] o_rdata,     // host read data
    input  wire logic       i_baud_tick, // bit clock pulse from timer
    input  wire logic       i_ser_in,    // serial data from terminal
    output logic            o_ser_out,   // serial data to terminal
    input  wire logic       i_rts,       // request to send, high active
    input  wire logic       i_dtr,       // terminal ready, high active
    output logic            o_cts,       // clear to send level
    output logic            o_dsr,       // data set ready level
    output logic            o_rx_req,    // receive ready request
    output logic            o_tx_req     // transmit ready request
);
    typedef enum logic [2:0] {
        USFG_IDLE, USFG_START, USFG_DATA, USFG_PAR, USFG_STOP
    } usfg_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bit_ticks(input logic [1:0] bf);
        case (bf)
            2'b10:   bit_ticks = usfg_pkg::BF_X16;
            2'b11:   bit_ticks = usfg_pkg::BF_X64;
            default: bit_ticks = usfg_pkg::BF_X1;
        endcase
    endfunction

    function automatic logic par_of(input logic [7:0] d,
                                    input logic even);
        par_of = even ? ^d : ~^d;
    endfunction

    // ------------------------------------------------------------
    // host decode and control registers
    // ------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] cmd_q;
    logic       want_mode_q;
    logic [7:0] rdata_q;
    wire        sel_data   = (i_addr == usfg_pkg::DATA_PORT_OFS);
    wire        sel_stat   = (i_addr == usfg_pkg::STATUS_PORT_OFS);
    wire        wr_ctl     = i_wr && sel_stat;
    wire        wr_mode    = wr_ctl && want_mode_q;
    wire        wr_cmd     = wr_ctl && !want_mode_q;
    wire        wr_data    = i_wr && sel_data;
    wire        rd_data    = i_rd && sel_data;
    wire        err_clr    = wr_cmd && i_wdata[usfg_pkg::CMD_ERR_CLR];
    wire        rx_on      = cmd_q[usfg_pkg::CMD_RX_ON] && !want_mode_q;
    // the terminal line and the enable bit act identically
    wire        tx_go      = cmd_q[usfg_pkg::CMD_TX_ON] && i_dtr;
    wire [1:0]  md_bf      = mode_q[usfg_pkg::MD_BAUD_LSB +: 2];
    wire [1:0]  md_len     = mode_q[usfg_pkg::MD_LEN_LSB +: 2];
    wire [1:0]  md_stop    = mode_q[usfg_pkg::MD_STOP_LSB +: 2];
    wire        md_par_on  = mode_q[usfg_pkg::MD_PAR_ON];
    wire        md_even    = mode_q[usfg_pkg::MD_EVEN];
    wire [7:0]  ticks      = bit_ticks(md_bf);
    wire [2:0]  last_bit   = {1'b1, md_len};
    wire [7:0]  len_mask   = 8'hff >> (3'h3 - md_len);
    wire [7:0]  half_ticks = (ticks > 8'h01) ? {1'b0, ticks[7:1]} : 8'h01;
    wire [8:0]  stop_prod  = {1'b0, ticks} *
                             ((md_stop == 2'b10) ? 9'h003 :
                              (md_stop == 2'b11) ? 9'h004 : 9'h002);
    wire [7:0]  stop_ticks = stop_prod[8:1];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_q      <= usfg_pkg::MODE_RST;
            cmd_q       <= usfg_pkg::CMD_RST;
            want_mode_q <= 1'b1;
        end else if (wr_mode) begin
            mode_q      <= i_wdata;
            want_mode_q <= 1'b0;
        end else if (wr_cmd) begin
            if (i_wdata[usfg_pkg::CMD_IRESET]) begin
                cmd_q       <= usfg_pkg::CMD_RST;
                want_mode_q <= 1'b1;
            end else begin
                cmd_q <= i_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // transmit queue
    // ------------------------------------------------------------
    logic        q_ready;
    logic        q_valid;
    logic [7:0]  q_data;
    logic        q_empty;
    usfg_state_t tx_st_q;
    wire         tx_pop = (tx_st_q == USFG_IDLE) && tx_go && q_valid;

    // back-pressure: a full queue drops transmit ready
    usfg_fifo #(
        .WIDTH (usfg_pkg::DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_txq (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_in_valid  (wr_data),
        .o_in_ready  (q_ready),
        .i_in_data   (i_wdata),
        .o_out_valid (q_valid),
        .i_out_ready (tx_pop),
        .o_out_data  (q_data),
        .o_empty     (q_empty)
    );

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic [7:0] tx_sh_q;
    logic [7:0] tx_cnt_q;
    logic [2:0] tx_bit_q;
    logic       tx_par_q;
    logic       tx_line_q;
    wire        tx_bit_end = i_baud_tick && (tx_cnt_q == 8'h01);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tx_st_q   <= USFG_IDLE;
            tx_sh_q   <= '0;
            tx_cnt_q  <= 8'h01;
            tx_bit_q  <= '0;
            tx_par_q  <= 1'b0;
            tx_line_q <= 1'b1;
        end else begin
            if (i_baud_tick && tx_cnt_q != 8'h01) begin
                tx_cnt_q <= tx_cnt_q - 8'h01;
            end
            case (tx_st_q)
                USFG_IDLE: begin
                    tx_line_q <= 1'b1;
                    if (tx_pop) begin
                        tx_sh_q   <= q_data;
                        tx_par_q  <= par_of(q_data & len_mask, md_even);
                        tx_line_q <= 1'b0;
                        tx_cnt_q  <= ticks;
                        tx_st_q   <= USFG_START;
                    end
                end
                USFG_START: begin
                    if (tx_bit_end) begin
                        tx_line_q <= tx_sh_q[0];
                        tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q  <= '0;
                        tx_cnt_q  <= ticks;
                        tx_st_q   <= USFG_DATA;
                    end
                end
                USFG_DATA: begin
                    if (tx_bit_end) begin
                        tx_cnt_q <= ticks;
                        if (tx_bit_q == last_bit) begin
                            // lengths run 5..8, encoded as 0..3
                            tx_line_q <= md_par_on ? tx_par_q : 1'b1;
                            tx_st_q   <= md_par_on ? USFG_PAR : USFG_STOP;
                            if (!md_par_on) begin
                                tx_cnt_q <= stop_ticks;
                            end
                        end else begin
                            tx_line_q <= tx_sh_q[0];
                            tx_sh_q   <= {1'b0, tx_sh_q[7:1]};
                            tx_bit_q  <= tx_bit_q + 3'h1;
                        end
                    end
                end
                USFG_PAR: begin
                    if (tx_bit_end) begin
                        tx_line_q <= 1'b1;
                        tx_cnt_q  <= stop_ticks;
                        tx_st_q   <= USFG_STOP;
                    end
                end
                USFG_STOP: begin
                    if (tx_bit_end) begin
                        tx_st_q <= USFG_IDLE;
                    end
                end
                default: tx_st_q <= USFG_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    usfg_state_t rx_st_q;
    logic [7:0]  rx_sh_q;
    logic [7:0]  rx_cnt_q;
    logic [2:0]  rx_bit_q;
    logic        rx_par_q;
    logic        rx_done;
    logic        rx_bad_stop;
    logic        rx_bad_par;
    logic        rx_all_zero;
    logic [7:0]  rx_hold_q;
    logic        rx_avail_q;
    logic        fe_q;
    logic        oe_q;
    logic        pe_q;
    logic        brk_q;
    wire         rx_smp = i_baud_tick && (rx_cnt_q == 8'h01);
    // right-align the assembled character for short lengths
    wire [7:0]   rx_char = rx_sh_q >> (3'h3 - md_len);

    always_comb begin
        rx_done     = 1'b0;
        rx_bad_stop = 1'b0;
        rx_bad_par  = 1'b0;
        rx_all_zero = 1'b0;
        if (rx_on && rx_st_q == USFG_STOP && rx_smp) begin
            rx_done     = 1'b1;
            rx_bad_stop = !i_ser_in;
            rx_bad_par  = md_par_on &&
                          (rx_par_q != par_of(rx_char, md_even));
            rx_all_zero = (rx_char == 8'h00) && !rx_par_q;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_st_q  <= USFG_IDLE;
            rx_sh_q  <= '0;
            rx_cnt_q <= 8'h01;
            rx_bit_q <= '0;
            rx_par_q <= 1'b0;
        end else if (!rx_on) begin
            rx_st_q <= USFG_IDLE;
        end else begin
            if (i_baud_tick && rx_cnt_q != 8'h01) begin
                rx_cnt_q <= rx_cnt_q - 8'h01;
            end
            case (rx_st_q)
                USFG_IDLE: begin
                    if (i_baud_tick && !i_ser_in) begin
                        rx_cnt_q <= half_ticks;
                        rx_bit_q <= '0;
                        rx_par_q <= 1'b0;
                        // at 1x the detecting tick is the only start sample
                        rx_st_q  <= (ticks == 8'h01) ? USFG_DATA : USFG_START;
                    end
                end
                USFG_START: begin
                    if (rx_smp) begin
                        rx_cnt_q <= ticks;
                        rx_bit_q <= '0;
                        rx_par_q <= 1'b0;
                        rx_st_q  <= i_ser_in ? USFG_IDLE : USFG_DATA;
                    end
                end
                USFG_DATA: begin
                    if (rx_smp) begin
                        rx_cnt_q <= ticks;
                        rx_sh_q  <= {i_ser_in, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 3'h1;
                        if (rx_bit_q == last_bit) begin
                            rx_st_q <= md_par_on ? USFG_PAR : USFG_STOP;
                        end
                    end
                end
                USFG_PAR: begin
                    if (rx_smp) begin
                        rx_cnt_q <= ticks;
                        rx_par_q <= i_ser_in;
                        rx_st_q  <= USFG_STOP;
                    end
                end
                USFG_STOP: begin
                    if (rx_smp) begin
                        rx_st_q <= USFG_IDLE;
                    end
                end
                default: rx_st_q <= USFG_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // received character and error flags
    // ------------------------------------------------------------
    // a character landing on the read cycle wins over the clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rx_hold_q  <= '0;
            rx_avail_q <= 1'b0;
            fe_q       <= 1'b0;
            oe_q       <= 1'b0;
            pe_q       <= 1'b0;
            brk_q      <= 1'b0;
        end else begin
            if (rx_done) begin
                rx_hold_q  <= rx_char;
                rx_avail_q <= 1'b1;
            end else if (rd_data) begin
                rx_avail_q <= 1'b0;
            end
            if (rx_bad_stop) begin
                fe_q <= 1'b1;
            end else if (err_clr) begin
                fe_q <= 1'b0;
            end
            if (rx_done && rx_avail_q && !rd_data) begin
                oe_q <= 1'b1;
            end else if (err_clr) begin
                oe_q <= 1'b0;
            end
            if (rx_bad_par) begin
                pe_q <= 1'b1;
            end else if (err_clr) begin
                pe_q <= 1'b0;
            end
            // a whole all-space frame marks a break until a mark returns
            if (rx_bad_stop && rx_all_zero) begin
                brk_q <= 1'b1;
            end else if (i_baud_tick && i_ser_in) begin
                brk_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status byte and outputs
    // ------------------------------------------------------------
    wire       txf      = q_ready;
    wire       transmitter_empty_flag      = q_empty && (tx_st_q == USFG_IDLE);
    wire       rxa      = rx_avail_q && rx_on;
    wire [7:0] status_w = {i_rts, brk_q, fe_q, oe_q,
                           pe_q, transmitter_empty_flag, rxa, txf};
    wire [7:0] rd_mux   = sel_stat ? status_w :
                          sel_data ? rx_hold_q : 8'h00;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= usfg_pkg::RDATA_RST;
        end else if (i_rd) begin
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ser_out <= 1'b1;
            o_cts     <= 1'b0;
            o_dsr     <= 1'b0;
            o_rx_req  <= 1'b0;
            o_tx_req  <= 1'b0;
        end else begin
            o_ser_out <= tx_line_q && !cmd_q[usfg_pkg::CMD_BREAK];
            o_cts     <= cmd_q[usfg_pkg::CMD_CTS];
            o_dsr     <= cmd_q[usfg_pkg::CMD_DSR];
            o_rx_req  <= rxa;
            o_tx_req  <= txf && tx_go;
        end
    end

    assign o_rdata = rdata_q;
endmodule

/* common/usfg_pkg.sv */
// shared constants of the serial status and flow gate block
package usfg_pkg;
    // ------------------------------------------------------------
    // host port map
    // ------------------------------------------------------------
    localparam logic [3:0] DATA_PORT_OFS   = 4'h6;
    localparam logic [3:0] STATUS_PORT_OFS = 4'h7;

    // ------------------------------------------------------------
    // line_status bit positions
    // ------------------------------------------------------------
    localparam int ST_RTS   = 7;
    localparam int ST_BRK   = 6;
    localparam int ST_FRAME = 5;
    localparam int ST_OVER  = 4;
    localparam int ST_PAR   = 3;
    localparam int ST_TXE   = 2;
    localparam int ST_RXA   = 1;
    localparam int ST_TXF   = 0;

    // ------------------------------------------------------------
    // mode byte fields
    // ------------------------------------------------------------
    localparam int MD_STOP_LSB = 6;
    localparam int MD_EVEN     = 5;
    localparam int MD_PAR_ON   = 4;
    localparam int MD_LEN_LSB  = 2;
    localparam int MD_BAUD_LSB = 0;

    // ------------------------------------------------------------
    // command byte fields
    // ------------------------------------------------------------
    localparam int CMD_IRESET  = 6;
    localparam int CMD_DSR     = 5;
    localparam int CMD_ERR_CLR = 4;
    localparam int CMD_BREAK   = 3;
    localparam int CMD_RX_ON   = 2;
    localparam int CMD_CTS     = 1;
    localparam int CMD_TX_ON   = 0;

    // ------------------------------------------------------------
    // reset values and baud factors
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] CMD_RST   = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [7:0] BF_X1     = 8'h01;
    localparam logic [7:0] BF_X16    = 8'h10;
    localparam logic [7:0] BF_X64    = 8'h40;

    // ------------------------------------------------------------
    // timing and sizes
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS      = 5000;
    localparam int WRITE_RECOVERY_NS  = 4000;
    localparam int WRITE_RECOVERY_CYC =
        (WRITE_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 32;
endpackage

/* design/usfg_fifo.sv */
// transmit queue with registered read data
`timescale 1ns/1ps
module usfg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             i_clk,       // system clock
    input  wire logic             i_rst,       // async reset, high
    input  wire logic             i_in_valid,  // write request
    output logic                  o_in_ready,  // room for a word
    input  wire logic [WIDTH-1:0] i_in_data,   // write word
    output logic                  o_out_valid, // word on output
    input  wire logic             i_out_ready, // consumer takes word
    output logic      [WIDTH-1:0] o_out_data,  // output word
    output logic                  o_empty      // nothing stored
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             ov_q;
    logic [WIDTH-1:0] od_q;
    wire              push;
    wire              load;

    // ------------------------------------------------------------
    // flow
    // ------------------------------------------------------------
    // the output register counts as one of the DEPTH words
    assign o_in_ready  = (cnt_q + {{AW{1'b0}}, ov_q}) != FULL_CNT;
    assign push        = i_in_valid && o_in_ready;
    assign load        = (cnt_q != '0) && (!ov_q || i_out_ready);
    assign cnt_d       = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    assign o_out_valid = ov_q;
    assign o_out_data  = od_q;
    assign o_empty     = (cnt_q == '0) && !ov_q;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wptr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
            ov_q   <= 1'b0;
            od_q   <= '0;
        end else begin
            cnt_q <= cnt_d;
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (load) begin
                rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
                od_q   <= mem_q[rptr_q];
                ov_q   <= 1'b1;
            end else if (i_out_ready) begin
                ov_q <= 1'b0;
            end
        end
    end
endmodule

/* bench/usfg_monitor.sv */
// port checker for the serial status and flow gate block
`timescale 1ns/1ps
module usfg_monitor (
    input wire logic       i_clk,       // clock
    input wire logic       i_rst,       // reset
    input wire logic [3:0] i_addr,      // port offset
    input wire logic       i_rd,        // read strobe
    input wire logic       i_wr,        // write strobe
    input wire logic [7:0] i_wdata,     // write data
    input wire logic [7:0] o_rdata,     // read data
    input wire logic       i_baud_tick, // bit tick
    input wire logic       i_ser_in,    // line in
    input wire logic       o_ser_out,   // line out
    input wire logic       i_rts,       // rts level
    input wire logic       i_dtr,       // dtr level
    input wire logic       o_cts,       // cts level
    input wire logic       o_dsr,       // dsr level
    input wire logic       o_rx_req,    // rx request
    input wire logic       o_tx_req     // tx request
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire st_rd  = i_rd && i_addr == usfg_pkg::STATUS_PORT_OFS;
    wire dat_rd = i_rd && i_addr == usfg_pkg::DATA_PORT_OFS;
    wire ctl_wr = i_wr && i_addr == usfg_pkg::STATUS_PORT_OFS;
    a_rts_mirror:
    assert property (st_rd |=> o_rdata[7] == $past(i_rts))
        else $error("status bit 7 differs from rts level");
    a_unmapped_zero:
    assert property (i_rd && !st_rd && !dat_rd |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold:
    assert property (!$past(i_rd) |-> $stable(o_rdata))
        else $error("read data moved without a read");
    a_cts_cause:
    assert property ($changed(o_cts) |-> $past(ctl_wr, 2))
        else $error("cts moved without a control write");
    a_dsr_cause:
    assert property ($changed(o_dsr) |-> $past(ctl_wr, 2))
        else $error("dsr moved without a control write");
    a_dtr_gate:
    assert property (!i_dtr && !$past(i_dtr) |-> !o_tx_req)
        else $error("transmit request with terminal not ready");
    a_txf_bit:
    assert property (st_rd && o_tx_req && !$past(i_wr) |=> o_rdata[0])
        else $error("holding free bit low while request high");
    a_rx_clear:
    assert property (dat_rd |-> ##2 !o_rx_req)
        else $error("receive request stayed after data read");
    cover property ($rose(o_rx_req));
    cover property (o_tx_req ##1 !o_tx_req);
    cover property ($fell(o_ser_out));
endmodule

bind usfg_top usfg_monitor mon_u (.i_clk, .i_rst, .i_addr, .i_rd, .i_wr,
    .i_wdata, .o_rdata, .i_baud_tick, .i_ser_in, .o_ser_out, .i_rts,
    .i_dtr, .o_cts, .o_dsr, .o_rx_req, .o_tx_req);

/* bench/usfg_term.sv */
// terminal model that shifts a bit pattern onto the serial line
`timescale 1ns/1ps
module usfg_term (
    input  wire logic        i_clk,   // one bit per cycle
    input  wire logic        i_rst,   // async reset, high
    input  wire logic        i_load,  // take a new pattern
    input  wire logic [15:0] i_frame, // bits, lsb first
    output logic             o_line   // serial line, idle mark
);
    logic [15:0] sh_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_q <= '1;
        end else if (i_load) begin
            sh_q <= i_frame;
        end else begin
            sh_q <= {1'b1, sh_q[15:1]}; // mark fills behind the frame
        end
    end
    assign o_line = sh_q[0];
endmodule

/* bench/uart_status_and_flow_gate_tb.sv */
// self-checking bench for the serial status and flow gate block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module uart_status_and_flow_gate_tb;
    logic        i_clk, i_rst, i_rd, i_wr, i_rts, i_dtr, load, ser;
    logic        o_ser_out, o_cts, o_dsr, o_rx_req, o_tx_req;
    logic [3:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata, rv;
    logic [15:0] frame;
    int          err_count, compares, n;
    usfg_top dut_u (.i_clk, .i_rst, .i_addr, .i_rd, .i_wr, .i_wdata,
        .o_rdata, .i_baud_tick(1'b1), .i_ser_in(ser), .o_ser_out, .i_rts,
        .i_dtr, .o_cts, .o_dsr, .o_rx_req, .o_tx_req);
    usfg_term term_u (.i_clk, .i_rst, .i_load(load), .i_frame(frame),
        .o_line(ser));
    task automatic acc(input logic [3:0] a, input logic w,
                       input logic [7:0] d);
        @(posedge i_clk);
        #1 {i_addr, i_wr, i_rd, i_wdata} = {a, w, !w, d};
        @(posedge i_clk);
        #1 {i_wr, i_rd} = 2'b00;
        @(posedge i_clk);
        #1 rv = o_rdata;
        if (w && a == usfg_pkg::STATUS_PORT_OFS) begin
            repeat (usfg_pkg::WRITE_RECOVERY_CYC) @(posedge i_clk);
        end
    endtask
    task automatic st(input logic [7:0] m, input logic [7:0] e);
        acc(4'h7, 1'b0, 8'h00);
        `CHK(rv & m, e)
    endtask
    task automatic send(input logic [15:0] f, input int w);
        @(posedge i_clk);
        #1 {load, frame} = {1'b1, f};
        @(posedge i_clk);
        #1 load = 1'b0;
        repeat (w) @(posedge i_clk);
    endtask
    task automatic results;
        $display("compares %0d, err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (40000) @(posedge i_clk);
        err_count++;
        results();
    end
    initial begin
        {i_rd, i_wr, load, i_addr, i_wdata, frame} = '0;
        {i_rts, i_dtr, i_rst} = 3'b111;
        repeat (5) @(posedge i_clk);
        #1 i_rst = 1'b0;
        st(8'h80, 8'h80);
        i_rts = 1'b0;
        st(8'h80, 8'h00);
        acc(4'h3, 1'b0, 8'h00);
        `CHK(rv, 8'h00)
        // mode 1x, 8 bits, no parity; bit 5 set would show on dsr
        acc(4'h7, 1'b1, 8'h6d);
        acc(4'h7, 1'b1, 8'h07);
        `CHK({o_dsr, o_cts}, 2'b01)
        st(8'h07, 8'h05);
        send({6'h3f, 1'b1, 8'ha5, 1'b0}, 20);
        st(8'h7a, 8'h02);
        acc(4'h6, 1'b0, 8'h00);
        `CHK(rv, 8'ha5)
        st(8'h02, 8'h00);
        send({6'h3f, 1'b1, 8'h11, 1'b0}, 20);
        send({6'h3f, 1'b1, 8'h22, 1'b0}, 20);
        st(8'h12, 8'h12);
        send({6'h3f, 1'b0, 8'h81, 1'b0}, 20);
        st(8'h20, 8'h20);
        acc(4'h7, 1'b1, 8'h17);
        st(8'h38, 8'h00);
        acc(4'h7, 1'b1, 8'h40);
        acc(4'h7, 1'b1, 8'h7d); // even parity on
        for (int p = 0; p < 2; p++) begin
            acc(4'h7, 1'b1, 8'h17);
            acc(4'h6, 1'b0, 8'h00);
            send({5'h1f, 1'b1, p[0], 8'h01, 1'b0}, 20);
            st(8'h08, {4'h0, ~p[0], 3'h0});
        end
        // a held space frame; status read while the line is still low
        send(16'h0000, 12);
        st(8'h40, 8'h40);
        repeat (20) @(posedge i_clk);
        st(8'h40, 8'h00);
        acc(4'h7, 1'b1, 8'h11);
        send({5'h1f, 1'b1, 1'b1, 8'h01, 1'b0}, 20);
        st(8'h02, 8'h00);
        `CHK(o_rx_req, 1'b0)
        i_dtr = 1'b0;
        acc(4'h7, 1'b1, 8'h07);
        acc(4'h6, 1'b1, 8'h3c);
        st(8'h05, 8'h01);
        n = 0;
        repeat (40) begin
            @(posedge i_clk);
            #1 n += (o_ser_out !== 1'b1);
        end
        `CHK(n, 0)
        repeat (31) acc(4'h6, 1'b1, 8'h55);
        st(8'h01, 8'h00);
        `CHK(o_tx_req, 1'b0)
        i_dtr = 1'b1;
        n = 0;
        while (o_ser_out === 1'b1 && n < 10) begin
            @(posedge i_clk);
            #1 n++;
        end
        `CHK(o_ser_out, 1'b0)
        repeat (200) @(posedge i_clk);
        st(8'h05, 8'h01);
        repeat (300) @(posedge i_clk);
        st(8'h05, 8'h05);
        results();
    end
endmodule
